// [src/lsi_line_status.sv]
`timescale 1ns/1ps
// What this block does
// - t1: prescale codes select 1.544-12.352 mhz, or 2.048-16.384 with source select
// - e1 with source select 0: codes select 2.048, 4.096, 8.192, 16.384 mhz
// - cmi invert bit inverts cmi at transmit tip output and receive tip input
// - cmi coding only while cmi enable bit is one
// - receive level reported live as 4-bit code in 2.5 db bands
// - open-circuit bit high while transmit outputs are open
// - current-limit bit shows limiter activity whether limiter enabled or not
// - bit-code bit high while a valid code is currently seen
// - pattern sync sets after 32 matches, clears at six errors in 64 bits
// - transmit clock loss set when no clock transition for one channel time
// - carrier loss status set whenever receive carrier is lost
// - jitter limit event sets near fifo limit, clears on status read
// - signaling change event when an enabled channel changes signaling state
// - timer event every 1 s or short interval counted on receive bits
// - level-low status after about 50 ms below threshold; interrupts both edges
// - mask bit one enables source; five conditions interrupt on both edges
// - jitter clock source select: master clock at 0, internal pll at 1
// - line mode select: t1 at 0, e1 at 1, picks prescale mapping
module lsi_line_status #(
	parameter int INPUT_LEVEL_LOW_CYCLES = lsi_pkg::LSI_INPUT_LEVEL_LOW_CYCLES,
	parameter int T1_BITS_1S = lsi_pkg::LSI_T1_BITS_1S,
	parameter int T1_BITS_SHORT = lsi_pkg::LSI_T1_BITS_SHORT,
	parameter int E1_BITS_1S = lsi_pkg::LSI_E1_BITS_1S,
	parameter int E1_BITS_SHORT = lsi_pkg::LSI_E1_BITS_SHORT
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire lsi_pkg::lsi_live_type live_in,
	input wire logic line_tx_clock_in,
	input wire logic rx_tip_in,
	input wire logic tx_line_data,
	input wire logic rx_bit_strobe,
	input wire logic rx_bit_error,
	input wire logic [31:0] signaling_change,
	output logic tx_tip_out,
	output logic rx_cmi_data,
	output logic cmi_mode_active,
	output lsi_pkg::lsi_cfg_type line_cfg,
	output logic [14:0] mclk_expected_khz,
	output logic irq
);
	localparam int LIVE_W = $bits(lsi_pkg::lsi_live_type);
	localparam int SYNC_W = LIVE_W + 2;

	logic [SYNC_W-1:0] meta_reg;
	logic [SYNC_W-1:0] stable_reg;
	lsi_pkg::lsi_live_type live;
	logic [3:0] level_prev_reg;
	logic [3:0] level_hold_reg;
	logic tx_clk_s;
	logic rx_tip_s;
	logic tx_clk_prev_reg;

	lsi_pkg::lsi_cfg_type cfg_reg;
	logic [7:0] mask_reg;
	logic [7:0] mask_next;
	logic [7:0] status_reg;
	logic [7:0] status_next;
	logic [7:0] sce_reg [0:3];
	logic [7:0] info_live;
	logic [7:0] cond_live;
	logic [7:0] cond_prev_reg;
	logic [7:0] set_vec;
	logic [7:0] read_data;

	logic [10:0] txclk_cnt_reg;
	logic [10:0] txclk_limit;
	logic tx_clock_loss_reg;
	logic [23:0] input_level_low_cnt_reg;
	logic input_level_low_reg;
	logic [20:0] timer_cnt_reg;
	logic [20:0] timer_limit;
	logic timer_event_reg;
	logic jfifo_prev_reg;
	logic pattern_sync_live;
	logic status_read;

	// byte-select helper, used by decode and read mux
	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		return a == target;
	endfunction

	// only the second stage of the synchroniser is read by logic
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			stable_reg <= '0;
		end else begin
			meta_reg <= {line_tx_clock_in, rx_tip_in, live_in};
			stable_reg <= meta_reg;
		end
	end

	assign live = stable_reg[LIVE_W-1:0];
	assign rx_tip_s = stable_reg[LIVE_W];
	assign tx_clk_s = stable_reg[LIVE_W+1];

	// the level code is a multi-bit pin word whose bits may be caught mid-change;
	// it is taken only once two synced samples agree, at one cycle of extra latency
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			level_prev_reg <= 4'h0;
			level_hold_reg <= 4'h0;
		end else begin
			level_prev_reg <= live.rx_level;
			if (live.rx_level == level_prev_reg) begin
				level_hold_reg <= level_prev_reg;
			end
		end
	end

	// irq must see a mask write at the same edge as the mask itself
	assign mask_next = (reg_wr && hit(reg_addr, lsi_pkg::LSI_ADDR_MASK)) ? reg_wdata : mask_reg;

	// register writes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= '0;
		end else if (reg_wr && hit(reg_addr, lsi_pkg::LSI_ADDR_CTRL2)) begin
			cfg_reg.line_mode_select <= reg_wdata[lsi_pkg::LSI_CTRL2_MODE];
			cfg_reg.jitter_clk_source_sel <= reg_wdata[lsi_pkg::LSI_CTRL2_JSRC];
		end else if (reg_wr && hit(reg_addr, lsi_pkg::LSI_ADDR_CTRL4)) begin
			cfg_reg.cmi_enable <= reg_wdata[lsi_pkg::LSI_CTRL4_CMI_ENABLE];
			cfg_reg.cmi_invert <= reg_wdata[lsi_pkg::LSI_CTRL4_CMI_INVERT];
			cfg_reg.clk_prescale_msb <= reg_wdata[lsi_pkg::LSI_CTRL4_PS_MSB];
			cfg_reg.clk_prescale_lsb <= reg_wdata[lsi_pkg::LSI_CTRL4_PS_LSB];
		end else if (reg_wr && hit(reg_addr, lsi_pkg::LSI_ADDR_AUX)) begin
			cfg_reg.counter_interval_sel <= reg_wdata[lsi_pkg::LSI_AUX_INTERVAL];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mask_reg <= lsi_pkg::LSI_RESET_BYTE;
		end else if (reg_wr && hit(reg_addr, lsi_pkg::LSI_ADDR_MASK)) begin
			mask_reg <= reg_wdata;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				sce_reg[i] <= lsi_pkg::LSI_RESET_BYTE;
			end
		end else if (reg_wr && reg_addr[7:2] == lsi_pkg::LSI_ADDR_SCE0[7:2]) begin
			sce_reg[reg_addr[1:0]] <= reg_wdata;
		end
	end

	// clock-rate view of the prescaler setting
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mclk_expected_khz <= 15'h0000;
		end else begin
			mclk_expected_khz <= lsi_pkg::lsi_mclk_khz(cfg_reg);
		end
	end

	assign line_cfg = cfg_reg;

	// cmi polarity on both the transmit tip and the receive tip
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_tip_out <= 1'b0;
			rx_cmi_data <= 1'b0;
			cmi_mode_active <= 1'b0;
		end else begin
			cmi_mode_active <= cfg_reg.cmi_enable;
			if (cfg_reg.cmi_enable) begin
				tx_tip_out <= tx_line_data ^ cfg_reg.cmi_invert;
				rx_cmi_data <= rx_tip_s ^ cfg_reg.cmi_invert;
			end else begin
				tx_tip_out <= tx_line_data;
				rx_cmi_data <= rx_tip_s;
			end
		end
	end

	// transmit clock watchdog: one channel time is eight bit periods
	assign txclk_limit = cfg_reg.line_mode_select ? 11'(lsi_pkg::LSI_E1_CHAN_CYCLES)
		: 11'(lsi_pkg::LSI_T1_CHAN_CYCLES);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_clk_prev_reg <= 1'b0;
			txclk_cnt_reg <= 11'h000;
			tx_clock_loss_reg <= 1'b0;
		end else begin
			tx_clk_prev_reg <= tx_clk_s;
			if (tx_clk_s != tx_clk_prev_reg) begin
				txclk_cnt_reg <= 11'h000;
				tx_clock_loss_reg <= 1'b0;
			end else if (txclk_cnt_reg >= txclk_limit - 11'h001) begin
				tx_clock_loss_reg <= 1'b1;
			end else begin
				txclk_cnt_reg <= txclk_cnt_reg + 11'h001;
			end
		end
	end

	// level-low qualifier; releases at once when the level recovers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			input_level_low_cnt_reg <= 24'h000000;
			input_level_low_reg <= 1'b0;
		end else if (!live.level_below_threshold) begin
			input_level_low_cnt_reg <= 24'h000000;
			input_level_low_reg <= 1'b0;
		end else if (input_level_low_cnt_reg >= 24'(INPUT_LEVEL_LOW_CYCLES - 1)) begin
			input_level_low_reg <= 1'b1;
		end else begin
			input_level_low_cnt_reg <= input_level_low_cnt_reg + 24'h000001;
		end
	end

	// timer counts recovered receive bits, not system clocks
	always_comb begin
		case ({cfg_reg.line_mode_select, cfg_reg.counter_interval_sel})
			2'b00: timer_limit = 21'(T1_BITS_1S - 1);
			2'b01: timer_limit = 21'(T1_BITS_SHORT - 1);
			2'b10: timer_limit = 21'(E1_BITS_1S - 1);
			default: timer_limit = 21'(E1_BITS_SHORT - 1);
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			timer_cnt_reg <= 21'h000000;
			timer_event_reg <= 1'b0;
		end else begin
			timer_event_reg <= 1'b0;
			if (rx_bit_strobe) begin
				if (timer_cnt_reg >= timer_limit) begin
					timer_cnt_reg <= 21'h000000;
					timer_event_reg <= 1'b1;
				end else begin
					timer_cnt_reg <= timer_cnt_reg + 21'h000001;
				end
			end
		end
	end

	lsi_pattern_sync u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.bit_strobe(rx_bit_strobe),
		.bit_error(rx_bit_error),
		.pattern_sync_live(pattern_sync_live)
	);

	// real-time information byte
	assign info_live = {pattern_sync_live,
		live.bit_code_detected,
		live.tx_current_limit_hit,
		live.tx_open_circuit,
		level_hold_reg};

	assign cond_live = {input_level_low_reg, 3'b000, live.rx_carrier_loss, live.tx_current_limit_hit,
		live.tx_open_circuit, tx_clock_loss_reg};

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cond_prev_reg <= 8'h00;
			jfifo_prev_reg <= 1'b0;
		end else begin
			cond_prev_reg <= cond_live;
			jfifo_prev_reg <= live.jitter_fifo_near_limit;
		end
	end

	// conditions latch on either edge; events on their pulse
	always_comb begin
		set_vec = (cond_live ^ cond_prev_reg) & lsi_pkg::LSI_COND_MASK;
		set_vec[lsi_pkg::LSI_ST_JITTER_FIFO_LIMIT_EVENT] = live.jitter_fifo_near_limit & ~jfifo_prev_reg;
		set_vec[lsi_pkg::LSI_ST_SIGCHG] = |(signaling_change & {sce_reg[3], sce_reg[2],
			sce_reg[1], sce_reg[0]});
		set_vec[lsi_pkg::LSI_ST_TIMER] = timer_event_reg;
	end

	assign status_read = reg_rd && hit(reg_addr, lsi_pkg::LSI_ADDR_STATUS);

	// read clears, but a live condition stays and a new set wins over the clear
	always_comb begin
		status_next = status_reg;
		if (status_read) begin
			status_next = status_reg & cond_live & lsi_pkg::LSI_COND_MASK;
		end
		status_next = status_next | set_vec;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= lsi_pkg::LSI_RESET_BYTE;
		end else begin
			status_reg <= status_next;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_next & mask_next);
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		read_data = 8'h00;
		if (hit(reg_addr, lsi_pkg::LSI_ADDR_INFO)) begin
			read_data = info_live;
		end else if (hit(reg_addr, lsi_pkg::LSI_ADDR_STATUS)) begin
			read_data = status_reg;
		end else if (hit(reg_addr, lsi_pkg::LSI_ADDR_MASK)) begin
			read_data = mask_reg;
		end else if (hit(reg_addr, lsi_pkg::LSI_ADDR_CTRL2)) begin
			read_data[lsi_pkg::LSI_CTRL2_MODE] = cfg_reg.line_mode_select;
			read_data[lsi_pkg::LSI_CTRL2_JSRC] = cfg_reg.jitter_clk_source_sel;
		end else if (hit(reg_addr, lsi_pkg::LSI_ADDR_CTRL4)) begin
			read_data[lsi_pkg::LSI_CTRL4_CMI_ENABLE] = cfg_reg.cmi_enable;
			read_data[lsi_pkg::LSI_CTRL4_CMI_INVERT] = cfg_reg.cmi_invert;
			read_data[lsi_pkg::LSI_CTRL4_PS_MSB] = cfg_reg.clk_prescale_msb;
			read_data[lsi_pkg::LSI_CTRL4_PS_LSB] = cfg_reg.clk_prescale_lsb;
		end else if (hit(reg_addr, lsi_pkg::LSI_ADDR_AUX)) begin
			read_data[lsi_pkg::LSI_AUX_INTERVAL] = cfg_reg.counter_interval_sel;
		end else if (reg_addr[7:2] == lsi_pkg::LSI_ADDR_SCE0[7:2]) begin
			read_data = sce_reg[reg_addr[1:0]];
		end
	end

	// data stands only in the cycle after the read strobe
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= read_data;
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule

// [src/lsi_pkg.sv]
package lsi_pkg;
	// register map
	localparam logic [7:0] LSI_ADDR_INFO = 8'h11;
	localparam logic [7:0] LSI_ADDR_STATUS = 8'h16;
	localparam logic [7:0] LSI_ADDR_MASK = 8'h17;
	localparam logic [7:0] LSI_ADDR_AUX = 8'h20;
	localparam logic [7:0] LSI_ADDR_SCE0 = 8'h30;
	localparam logic [7:0] LSI_ADDR_SCE1 = 8'h31;
	localparam logic [7:0] LSI_ADDR_SCE2 = 8'h32;
	localparam logic [7:0] LSI_ADDR_SCE3 = 8'h33;
	localparam logic [7:0] LSI_ADDR_CTRL2 = 8'h79;
	localparam logic [7:0] LSI_ADDR_CTRL4 = 8'h7b;
	localparam logic [7:0] LSI_RESET_BYTE = 8'h00;

	// field positions
	localparam int LSI_CTRL2_MODE = 7;
	localparam int LSI_CTRL2_JSRC = 3;
	localparam int LSI_CTRL4_CMI_ENABLE = 7;
	localparam int LSI_CTRL4_CMI_INVERT = 6;
	localparam int LSI_CTRL4_PS_MSB = 5;
	localparam int LSI_CTRL4_PS_LSB = 4;
	localparam int LSI_AUX_INTERVAL = 0;
	localparam int LSI_ST_TXCLK = 0;
	localparam int LSI_ST_OPEN = 1;
	localparam int LSI_ST_CURLIM = 2;
	localparam int LSI_ST_CARRIER = 3;
	localparam int LSI_ST_JITTER_FIFO_LIMIT_EVENT = 4;
	localparam int LSI_ST_SIGCHG = 5;
	localparam int LSI_ST_TIMER = 6;
	localparam int LSI_ST_INPUT_LEVEL_LOW = 7;
	// status bits that latch on both edges and stay set while live
	localparam logic [7:0] LSI_COND_MASK = 8'h8f;

	// timing
	localparam int LSI_CLK_PERIOD_NS = 5;
	localparam int LSI_T1_CHAN_TIME_NS = 5181;
	localparam int LSI_E1_CHAN_TIME_NS = 3906;
	localparam int LSI_T1_CHAN_CYCLES = LSI_T1_CHAN_TIME_NS / LSI_CLK_PERIOD_NS;
	localparam int LSI_E1_CHAN_CYCLES = LSI_E1_CHAN_TIME_NS / LSI_CLK_PERIOD_NS;
	localparam int LSI_INPUT_LEVEL_LOW_TIME_MS = 50;
	localparam int LSI_INPUT_LEVEL_LOW_CYCLES = LSI_INPUT_LEVEL_LOW_TIME_MS * 1000000 / LSI_CLK_PERIOD_NS;
	localparam int LSI_T1_BITS_1S = 1544000;
	localparam int LSI_T1_BITS_SHORT = 64848;
	localparam int LSI_E1_BITS_1S = 2048000;
	localparam int LSI_E1_BITS_SHORT = 128000;
	localparam int LSI_SYNC_MATCH = 32;
	localparam int LSI_SYNC_WINDOW = 64;
	localparam int LSI_SYNC_ERR_LIMIT = 6;
	localparam logic [14:0] LSI_T1_BASE_KHZ = 15'h0608;
	localparam logic [14:0] LSI_E1_BASE_KHZ = 15'h0800;

	typedef struct packed {
		logic line_mode_select;
		logic jitter_clk_source_sel;
		logic cmi_enable;
		logic cmi_invert;
		logic clk_prescale_msb;
		logic clk_prescale_lsb;
		logic counter_interval_sel;
	} lsi_cfg_type;

	typedef struct packed {
		logic [3:0] rx_level;
		logic tx_open_circuit;
		logic tx_current_limit_hit;
		logic bit_code_detected;
		logic rx_carrier_loss;
		logic jitter_fifo_near_limit;
		logic level_below_threshold;
	} lsi_live_type;

	typedef enum logic [1:0] {
		LSI_HUNT = 2'b01,
		LSI_LOCK = 2'b10
	} lsi_sync_state_type;

	// expected master clock for the prescaler code, in kHz
	function automatic logic [14:0] lsi_mclk_khz(input lsi_cfg_type c);
		logic [14:0] base;
		base = (c.line_mode_select || c.jitter_clk_source_sel) ? LSI_E1_BASE_KHZ : LSI_T1_BASE_KHZ;
		return base << {c.clk_prescale_msb, c.clk_prescale_lsb};
	endfunction
endpackage

// [src/lsi_pattern_sync.sv]
`timescale 1ns/1ps
module lsi_pattern_sync (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic bit_strobe,
	input wire logic bit_error,
	output logic pattern_sync_live
);
	lsi_pkg::lsi_sync_state_type state_reg;
	logic [5:0] match_reg;
	logic [5:0] window_reg;
	logic [2:0] err_reg;

	function automatic logic [5:0] lsi_inc6(input logic [5:0] v);
		return v + 6'h01;
	endfunction

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= lsi_pkg::LSI_HUNT;
			match_reg <= 6'h00;
			window_reg <= 6'h00;
			err_reg <= 3'h0;
		end else if (bit_strobe) begin
			case (state_reg)
				lsi_pkg::LSI_HUNT: begin
					window_reg <= 6'h00;
					err_reg <= 3'h0;
					if (bit_error) begin
						match_reg <= 6'h00;
					end else if (match_reg == 6'(lsi_pkg::LSI_SYNC_MATCH - 1)) begin
						match_reg <= 6'h00;
						state_reg <= lsi_pkg::LSI_LOCK;
					end else begin
						match_reg <= lsi_inc6(match_reg);
					end
				end
				lsi_pkg::LSI_LOCK: begin
					if (bit_error && err_reg == 3'(lsi_pkg::LSI_SYNC_ERR_LIMIT - 1)) begin
						state_reg <= lsi_pkg::LSI_HUNT;
						window_reg <= 6'h00;
						err_reg <= 3'h0;
					end else if (window_reg == 6'(lsi_pkg::LSI_SYNC_WINDOW - 1)) begin
						window_reg <= 6'h00;
						err_reg <= 3'h0;
					end else begin
						window_reg <= lsi_inc6(window_reg);
						err_reg <= err_reg + {2'h0, bit_error};
					end
				end
				default: begin
					state_reg <= lsi_pkg::LSI_HUNT;
				end
			endcase
		end
	end

	assign pattern_sync_live = (state_reg == lsi_pkg::LSI_LOCK);
endmodule

// [tb/lsi_line_status_sva.sv]
`timescale 1ns/1ps
module lsi_line_status_sva (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic tx_line_data,
	input wire logic tx_tip_out,
	input wire logic rx_tip_in,
	input wire logic rx_cmi_data,
	input wire logic cmi_mode_active,
	input wire lsi_pkg::lsi_cfg_type line_cfg,
	input wire logic [14:0] mclk_expected_khz,
	input wire logic irq
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// one-cycle delayed copies, since $past cannot select struct members
	lsi_pkg::lsi_cfg_type cfg_d;
	logic tx_d;
	logic [7:0] wdata_d;
	always_ff @(posedge clock) begin
		cfg_d <= line_cfg;
		tx_d <= tx_line_data;
		wdata_d <= reg_wdata;
	end
	property p_rdata_idle;
		$past(rst_n) && !$past(reg_rd) |-> reg_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside answer");
	property p_cmi_tx;
		$past(rst_n) |-> tx_tip_out == (tx_d ^ (cfg_d.cmi_enable & cfg_d.cmi_invert));
	endproperty
	a_cmi_tx: assert property (p_cmi_tx) else $error("transmit tip polarity wrong");
	property p_cmi_rx;
		$past(rst_n, 3) |-> rx_cmi_data == ($past(rx_tip_in, 3) ^ (cfg_d.cmi_enable & cfg_d.cmi_invert));
	endproperty
	a_cmi_rx: assert property (p_cmi_rx) else $error("receive tip polarity wrong");
	property p_cmi_mode;
		$past(rst_n) |-> cmi_mode_active == cfg_d.cmi_enable;
	endproperty
	a_cmi_mode: assert property (p_cmi_mode) else $error("cmi mode does not follow enable");
	property p_mclk;
		$past(rst_n) |-> mclk_expected_khz == (((cfg_d.line_mode_select | cfg_d.jitter_clk_source_sel) ?
			15'h0800 : 15'h0608) << {cfg_d.clk_prescale_msb, cfg_d.clk_prescale_lsb});
	endproperty
	a_mclk: assert property (p_mclk) else $error("master clock rate wrong");
	property p_cfg4;
		reg_wr && reg_addr == lsi_pkg::LSI_ADDR_CTRL4 |=> {line_cfg.cmi_enable, line_cfg.cmi_invert,
			line_cfg.clk_prescale_msb, line_cfg.clk_prescale_lsb} == wdata_d[7:4];
	endproperty
	a_cfg4: assert property (p_cfg4) else $error("coding control write lost");
	property p_cfg2;
		reg_wr && reg_addr == lsi_pkg::LSI_ADDR_CTRL2 |=> line_cfg.line_mode_select == wdata_d[7] &&
			line_cfg.jitter_clk_source_sel == wdata_d[3];
	endproperty
	a_cfg2: assert property (p_cfg2) else $error("mode control write lost");
	property p_irq_hold;
		irq && !reg_rd && !reg_wr |=> irq;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without read");
	property p_irq_mask_off;
		reg_wr && reg_addr == lsi_pkg::LSI_ADDR_MASK && reg_wdata == 8'h00 ##1
			!(reg_wr && reg_addr == lsi_pkg::LSI_ADDR_MASK) |=> !irq;
	endproperty
	a_irq_mask_off: assert property (p_irq_mask_off) else $error("irq with all masked");
endmodule

bind lsi_line_status lsi_line_status_sva u_lsi_line_status_sva (.clock(clock), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.tx_line_data(tx_line_data), .tx_tip_out(tx_tip_out), .cmi_mode_active(cmi_mode_active),
	.rx_tip_in(rx_tip_in), .rx_cmi_data(rx_cmi_data),
	.line_cfg(line_cfg), .mclk_expected_khz(mclk_expected_khz), .irq(irq));

// [tb/lsi_line_model.sv]
`timescale 1ns/1ps
module lsi_line_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_run,
	input wire logic strobe_run,
	input wire logic err_on,
	input wire lsi_pkg::lsi_live_type live_cfg,
	output lsi_pkg::lsi_live_type live_in = '0,
	output logic line_tx_clock_in = 1'b0,
	output logic rx_tip_in = 1'b0,
	output logic rx_bit_strobe = 1'b0,
	output logic rx_bit_error = 1'b0
);
	logic [1:0] div_reg = 2'd0;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 2'd0;
			rx_bit_strobe <= 1'b0;
		end else begin
			div_reg <= div_reg + 2'd1;
			live_in <= live_cfg;
			// line clock stands still while stopped, no free-running default
			if (clk_run && div_reg == 2'd0) begin
				line_tx_clock_in <= ~line_tx_clock_in;
			end
			rx_tip_in <= div_reg[1];
			rx_bit_strobe <= strobe_run && div_reg == 2'd3;
			// error line is junk between strobes so nothing leans on a held value
			rx_bit_error <= (div_reg == 2'd3) ? err_on : div_reg[0];
		end
	end
endmodule

// [tb/lsi_line_status_bench.sv]
`timescale 1ns/1ps
module lsi_line_status_bench;
	localparam logic [7:0] A_ST = lsi_pkg::LSI_ADDR_STATUS;
	localparam logic [7:0] A_IN = lsi_pkg::LSI_ADDR_INFO;
	localparam logic [7:0] A_MK = lsi_pkg::LSI_ADDR_MASK;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic tx_line_data = 1'b0;
	logic [31:0] signaling_change = 32'h0;
	logic clk_run = 1'b1;
	logic strobe_run = 1'b0;
	logic err_on = 1'b0;
	lsi_pkg::lsi_live_type live_cfg = '0;
	lsi_pkg::lsi_live_type live_in;
	lsi_pkg::lsi_cfg_type line_cfg;
	logic line_tx_clock_in, rx_tip_in, rx_bit_strobe, rx_bit_error;
	logic tx_tip_out, rx_cmi_data, cmi_mode_active, irq;
	logic [7:0] reg_rdata, v, mon_e, mon_m;
	logic [14:0] mclk_expected_khz, base;
	logic [31:0] seed = 32'h0ca22190;
	logic [7:0] exp_q[$];
	logic [7:0] msk_q[$];
	logic rd_seen = 1'b0;
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;

	lsi_line_status #(.INPUT_LEVEL_LOW_CYCLES(20), .T1_BITS_1S(10), .T1_BITS_SHORT(5), .E1_BITS_1S(12),
		.E1_BITS_SHORT(6)) u_lsi_line_status (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .live_in(live_in),
		.line_tx_clock_in(line_tx_clock_in), .rx_tip_in(rx_tip_in), .tx_line_data(tx_line_data),
		.rx_bit_strobe(rx_bit_strobe), .rx_bit_error(rx_bit_error), .signaling_change(signaling_change),
		.tx_tip_out(tx_tip_out), .rx_cmi_data(rx_cmi_data), .cmi_mode_active(cmi_mode_active),
		.line_cfg(line_cfg), .mclk_expected_khz(mclk_expected_khz), .irq(irq));
	lsi_line_model u_lsi_line_model (.clock(clock), .rst_n(rst_n), .clk_run(clk_run), .strobe_run(strobe_run),
		.err_on(err_on), .live_cfg(live_cfg), .live_in(live_in), .line_tx_clock_in(line_tx_clock_in),
		.rx_tip_in(rx_tip_in), .rx_bit_strobe(rx_bit_strobe), .rx_bit_error(rx_bit_error));

	always #2.5 clock = ~clock;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic end_sim;
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] e, input logic [15:0] got);
		samples_checked++;
		if (got !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, e, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	// expectation noted with a mask; bits outside it are not judged
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		@(posedge clock);
		reg_rd <= 1'b0;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic pulse(input logic [31:0] p);
		@(posedge clock);
		signaling_change <= p;
		@(posedge clock);
		signaling_change <= 32'h0;
		idle(2);
	endtask

	// negedge sampling keeps the compare clear of the register update
	always @(negedge clock) begin
		if (rd_seen) begin
			mon_e = exp_q.pop_front();
			mon_m = msk_q.pop_front();
			if (mon_m != 8'h00) check("reg_rdata", {8'h00, mon_e}, {8'h00, reg_rdata & mon_m});
		end
		rd_seen = reg_rd;
	end

	always @(posedge clock) begin
		seed <= lfsr(seed);
		tx_line_data <= seed[3];
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			end_sim();
		end
	end

	initial begin
		idle(2);
		rst_n <= 1'b1;
		rd(A_IN, 8'h00, 8'hff);
		rd(A_ST, 8'h00, 8'hff);
		rd(A_MK, 8'h00, 8'hff);
		rd(8'h55, 8'h00, 8'hff);
		v = seed[7:0];
		wr(A_MK, v);
		rd(A_MK, v, 8'hff);
		wr(A_IN, 8'hff);
		rd(A_IN, 8'h00, 8'hff);
		wr(A_ST, 8'hff);
		rd(A_ST, 8'h00, 8'hff);
		wr(A_MK, 8'h00);
		for (int i = 0; i < 16; i++) begin
			wr(lsi_pkg::LSI_ADDR_CTRL2, {i[3], 3'b000, i[2], 3'b000});
			wr(lsi_pkg::LSI_ADDR_CTRL4, {seed[1:0], i[1:0], 4'h0});
			idle(2);
			base = (i[3] | i[2]) ? 15'h0800 : 15'h0608;
			check("mclk_expected_khz", {1'b0, base << i[1:0]}, {1'b0, mclk_expected_khz});
		end
		wr(lsi_pkg::LSI_ADDR_CTRL2, 8'h00);
		wr(lsi_pkg::LSI_ADDR_CTRL4, 8'h00);
		v = seed[7:0];
		live_cfg <= {v[3:0], v[4], v[5], v[6], 3'b000};
		idle(6);
		rd(A_IN, {1'b0, v[6], v[5], v[4], v[3:0]}, 8'h7f);
		live_cfg <= '0;
		idle(6);
		rd(A_ST, 8'h00, 8'h00);
		wr(A_MK, 8'h02);
		live_cfg.tx_open_circuit <= 1'b1;
		live_cfg.rx_carrier_loss <= 1'b1;
		idle(6);
		check("irq", 16'h1, {15'h0, irq});
		rd(A_ST, 8'h0a, 8'h0a);
		rd(A_ST, 8'h0a, 8'h0a);
		live_cfg.tx_open_circuit <= 1'b0;
		live_cfg.rx_carrier_loss <= 1'b0;
		idle(6);
		check("irq", 16'h1, {15'h0, irq});
		wr(A_MK, 8'h00);
		idle(3);
		check("irq", 16'h0, {15'h0, irq});
		rd(A_ST, 8'h0a, 8'h0a);
		rd(A_ST, 8'h00, 8'h0a);
		live_cfg.jitter_fifo_near_limit <= 1'b1;
		idle(6);
		rd(A_ST, 8'h10, 8'h10);
		rd(A_ST, 8'h00, 8'h10);
		live_cfg.jitter_fifo_near_limit <= 1'b0;
		wr(lsi_pkg::LSI_ADDR_SCE0, 8'h01);
		pulse(32'h2);
		rd(A_ST, 8'h00, 8'h20);
		pulse(32'h1);
		rd(A_ST, 8'h20, 8'h20);
		live_cfg.level_below_threshold <= 1'b1;
		idle(8);
		rd(A_ST, 8'h00, 8'h80);
		idle(20);
		rd(A_ST, 8'h80, 8'h80);
		live_cfg.level_below_threshold <= 1'b0;
		idle(4);
		rd(A_ST, 8'h80, 8'h80);
		rd(A_ST, 8'h00, 8'h80);
		wr(lsi_pkg::LSI_ADDR_AUX, 8'h01);
		rd(lsi_pkg::LSI_ADDR_AUX, 8'h01, 8'hff);
		strobe_run <= 1'b1;
		idle(200);
		rd(A_IN, 8'h80, 8'h80);
		rd(A_ST, 8'h40, 8'h40);
		err_on <= 1'b1;
		idle(40);
		rd(A_IN, 8'h00, 8'h80);
		strobe_run <= 1'b0;
		err_on <= 1'b0;
		rd(A_ST, 8'h00, 8'h00);
		clk_run <= 1'b0;
		idle(900);
		rd(A_ST, 8'h00, 8'h01);
		idle(300);
		rd(A_ST, 8'h01, 8'h01);
		clk_run <= 1'b1;
		idle(3);
		end_sim();
	end
endmodule
